// ==== rtl/conversion_result_fifo.sv ====
// Conversion result buffer with serial register port, standby diagnostic gating
// and temperature-sensor channel detection.
// Assumes result_* and standby inputs come from logic on clk; serial pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module conversion_result_fifo import fifo_pkg::*; #(
    parameter logic [4:0] TEMP_SENSOR_SEL = 5'h10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic result_valid,
    input wire logic [DATA_W-1:0] result_data,
    input wire logic [3:0] result_channel,
    input wire logic result_above_high,
    input wire logic result_below_low,
    input wire logic standby_mode,
    input wire logic standby_diag_gate,
    input wire logic osc_diag_errors_en,
    input wire logic [4:0] positive_input_select,
    input wire logic [4:0] negative_input_select,
    output logic diag_enable,
    output logic osc_keep_on,
    output logic temp_sensor_pos,
    output logic temp_sensor_neg,
    output logic irq
);
    typedef enum logic [2:0] {ST_CMD, ST_WR, ST_RD, ST_CNT, ST_STREAM} spi_state_type;

    spi_state_type state_ff;
    logic cs_s1_ff, cs_s2_ff, sclk_s1_ff, sclk_s2_ff, sclk_s3_ff, mosi_s1_ff, mosi_s2_ff;
    logic [23:0] shift_in_ff;
    logic [4:0] bit_cnt_ff;
    logic [5:0] addr_ff;
    logic [23:0] ctrl_ff;
    logic [WORD_W-1:0] tx_ff;
    logic [WORD_W-1:0] next_word_ff;
    logic [5:0] bits_left_ff;
    logic [CW-1:0] remaining_ff;
    logic fetch_pend_ff, lock_ff;
    logic wr_err_ff, rd_err_ff, ovr_ff, high_ff, low_ff;
    logic dout_ff, dout_oe_ff, irq_ff, diag_en_ff, osc_keep_ff, temp_pos_ff, temp_neg_ff;

    logic rise, fall, cmd_done, wr_done, cnt_done, load_word;
    logic [7:0] rx_byte;
    logic [1:0] mode;
    logic enabled, wm_mode, stream_mode, accept, store_en, discard, service, pop_en;
    logic [CW-1:0] count, level;
    logic [WORD_W-1:0] ring_out, store_word;
    logic [7:0] status;

    // Serial pin synchronisers; edges are taken from the second and third stages
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {cs_s1_ff, cs_s2_ff} <= 2'h3;
            {sclk_s1_ff, sclk_s2_ff, sclk_s3_ff} <= 3'h7;
            {mosi_s1_ff, mosi_s2_ff} <= 2'h0;
        end else begin
            {cs_s1_ff, cs_s2_ff} <= {spi_cs_n, cs_s1_ff};
            {sclk_s1_ff, sclk_s2_ff, sclk_s3_ff} <= {spi_sclk, sclk_s1_ff, sclk_s2_ff};
            {mosi_s1_ff, mosi_s2_ff} <= {spi_mosi, mosi_s1_ff};
        end
    end

    assign rise = !cs_s2_ff && sclk_s2_ff && !sclk_s3_ff;
    assign fall = !cs_s2_ff && !sclk_s2_ff && sclk_s3_ff;
    assign rx_byte = {shift_in_ff[6:0], mosi_s2_ff};
    assign cmd_done = rise && (state_ff == ST_CMD) && (bit_cnt_ff == CMD_LAST);
    assign wr_done = rise && (state_ff == ST_WR) && (bit_cnt_ff == CTRL_LAST)
        && (addr_ff == REG_CTRL);
    assign cnt_done = rise && (state_ff == ST_CNT) && (bit_cnt_ff == CNT_LAST);
    assign load_word = fall && (state_ff == ST_STREAM) && (bits_left_ff == 6'h00)
        && (remaining_ff != '0);

    // Mode decode; the unused code 11 behaves as disabled
    assign mode = ctrl_ff[MODE_LSB +: 2];
    assign wm_mode = (mode == MODE_WM);
    assign stream_mode = (mode == MODE_STREAM);
    assign enabled = wm_mode || stream_mode;
    assign level = level_of(ctrl_ff[WM_LSB +: 8]);

    // Admission of a new result; watermark mode locks until drained
    assign accept = stream_mode || (wm_mode && !lock_ff && (count < level));
    assign store_en = result_valid && accept;
    assign discard = result_valid && wm_mode && !accept;
    assign store_word = {1'b0, result_above_high || result_below_low,
        (CW'(count + 1'b1) >= level), 1'b0, result_channel, result_data};

    // Reads yield to a result write in the same cycle
    assign service = fetch_pend_ff && !store_en && !cs_s2_ff;
    assign pop_en = service && (count != '0);

    assign status = {wr_err_ff || rd_err_ff, wr_err_ff, rd_err_ff, high_ff, low_ff, ovr_ff,
        enabled && (count >= level), count == '0};

    // Register readback value, left aligned for the shifter
    function automatic logic [WORD_W-1:0] read_reg(input logic [5:0] a, input logic [23:0] c,
                                                   input logic [7:0] s);
        read_reg = '0;
        if (a == REG_CTRL) begin
            read_reg = {c, 8'h00};
        end else if (a == REG_STATUS) begin
            read_reg = {s, 24'h000000};
        end
    endfunction

    sample_ring u_ring (
        .clk(clk),
        .rst_n(rst_n),
        .clear(!enabled),
        .push(store_en),
        .pop(pop_en),
        .push_data(store_word),
        .pop_data(ring_out),
        .count(count)
    );

    // Serial frame sequencer
    always_ff @(posedge clk) begin
        if (!rst_n || cs_s2_ff) begin
            state_ff <= ST_CMD;
            bit_cnt_ff <= '0;
            addr_ff <= '0;
        end else if (rise) begin
            bit_cnt_ff <= 5'(bit_cnt_ff + 1'b1);
            case (state_ff)
                ST_CMD: begin
                    if (cmd_done) begin
                        bit_cnt_ff <= '0;
                        addr_ff <= rx_byte[5:0];
                        if (!rx_byte[CMD_READ_BIT]) begin
                            state_ff <= ST_WR;
                        end else if (rx_byte[5:0] == REG_DATA) begin
                            state_ff <= ST_CNT;
                        end else begin
                            state_ff <= ST_RD;
                        end
                    end
                end
                ST_WR: begin
                    if (bit_cnt_ff == CTRL_LAST) begin
                        state_ff <= ST_RD;
                    end
                end
                ST_CNT: begin
                    if (cnt_done) begin
                        state_ff <= ST_STREAM;
                    end
                end
                default: begin
                    bit_cnt_ff <= bit_cnt_ff;
                end
            endcase
        end
    end

    // Incoming bit shifter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_in_ff <= '0;
        end else if (rise) begin
            shift_in_ff <= {shift_in_ff[22:0], mosi_s2_ff};
        end
    end

    // Control register; reserved bits stay zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_done) begin
            ctrl_ff <= {shift_in_ff[22:0], mosi_s2_ff} & CTRL_WMASK;
        end
    end

    // Words left to send in a readback
    always_ff @(posedge clk) begin
        if (!rst_n || cs_s2_ff) begin
            remaining_ff <= '0;
        end else if (cnt_done) begin
            remaining_ff <= level_of(rx_byte);
        end else if (load_word) begin
            remaining_ff <= CW'(remaining_ff - 1'b1);
        end
    end

    // Prefetch of the next entry; an empty buffer yields zeros
    always_ff @(posedge clk) begin
        if (!rst_n || cs_s2_ff) begin
            fetch_pend_ff <= 1'b0;
            next_word_ff <= '0;
        end else begin
            if (service) begin
                fetch_pend_ff <= 1'b0;
                next_word_ff <= '0;
                if (pop_en) begin
                    next_word_ff <= ring_out | ((count == 9'h001) ? (32'h1 << (DATA_W + HDR_EMPTY))
                                                                 : 32'h0);
                end
            end
            if (cnt_done || (load_word && (remaining_ff > 9'h001))) begin
                fetch_pend_ff <= 1'b1;
            end
        end
    end

    // Outgoing shifter and data pin; with select high the pin is high on a store or while watermark mode is unlocked
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_ff <= '0;
            bits_left_ff <= '0;
            dout_ff <= 1'b0;
            dout_oe_ff <= 1'b0;
        end else begin
            dout_oe_ff <= !cs_s2_ff || enabled;
            if (cs_s2_ff) begin
                tx_ff <= '0;
                bits_left_ff <= '0;
                dout_ff <= enabled && (store_en || (wm_mode && !lock_ff));
            end else if (cmd_done) begin
                tx_ff <= read_reg(rx_byte[5:0], ctrl_ff, status);
            end else if (load_word) begin
                if (ctrl_ff[ADD_HDR_BIT]) begin
                    dout_ff <= next_word_ff[WORD_W-1];
                    tx_ff <= {next_word_ff[WORD_W-2:0], 1'b0};
                    bits_left_ff <= 6'(LEN_HDR - 1'b1);
                end else begin
                    dout_ff <= next_word_ff[DATA_W-1];
                    tx_ff <= {next_word_ff[DATA_W-2:0], 9'h000};
                    bits_left_ff <= 6'(LEN_NOHDR - 1'b1);
                end
            end else if (fall) begin
                dout_ff <= tx_ff[WORD_W-1];
                tx_ff <= {tx_ff[WORD_W-2:0], 1'b0};
                if (bits_left_ff != 6'h00) begin
                    bits_left_ff <= 6'(bits_left_ff - 1'b1);
                end
            end
        end
    end

    // Watermark lock: set at the level, released once drained or when watermark mode is left
    always_ff @(posedge clk) begin
        if (!rst_n || !wm_mode || (count == '0)) begin
            lock_ff <= 1'b0;
        end else if (count >= level) begin
            lock_ff <= 1'b1;
        end
    end

    // Sticky flags; a set in the same cycle as a clear wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {wr_err_ff, rd_err_ff, ovr_ff, high_ff, low_ff} <= 5'h00;
        end else begin
            if (!enabled) begin
                {wr_err_ff, rd_err_ff, high_ff, low_ff} <= 4'h0;
            end
            if (!enabled || (pop_en && (count == 9'h001))) begin
                ovr_ff <= 1'b0;
            end
            if (discard) begin
                wr_err_ff <= 1'b1;
                ovr_ff <= 1'b1;
            end
            if (store_en && stream_mode && (count == DEPTH_CNT)) begin
                ovr_ff <= 1'b1;
            end
            if (service && (count == '0)) begin
                rd_err_ff <= 1'b1;
            end
            if (store_en && result_above_high) begin
                high_ff <= 1'b1;
            end
            if (store_en && result_below_low) begin
                low_ff <= 1'b1;
            end
        end
    end

    // Interrupt: each event gated by its own enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(status[IRQ_SRC_W-1:0] & ctrl_ff[IRQ_EN_LSB +: IRQ_SRC_W]);
        end
    end

    // Standby diagnostic gating and channel detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            diag_en_ff <= 1'b1;
            osc_keep_ff <= 1'b0;
            temp_pos_ff <= 1'b0;
            temp_neg_ff <= 1'b0;
        end else begin
            diag_en_ff <= !(standby_mode && standby_diag_gate);
            osc_keep_ff <= standby_mode && standby_diag_gate && osc_diag_errors_en;
            temp_pos_ff <= (positive_input_select == TEMP_SENSOR_SEL);
            temp_neg_ff <= (negative_input_select == TEMP_SENSOR_SEL);
        end
    end

    assign spi_miso = dout_ff;
    assign spi_miso_oe = dout_oe_ff;
    assign irq = irq_ff;
    assign diag_enable = diag_en_ff;
    assign osc_keep_on = osc_keep_ff;
    assign temp_sensor_pos = temp_pos_ff;
    assign temp_sensor_neg = temp_neg_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_locked_arrival;
        result_valid && wm_mode && lock_ff;
    endsequence

    sequence s_full_stream_store;
        store_en && stream_mode && (count == DEPTH_CNT) && !pop_en;
    endsequence

    a_mode_off_clears: assert property (!enabled |=> (count == '0))
        else $error("disabled buffer still holds entries");
    a_locked_discard: assert property (s_locked_arrival |=> wr_err_ff && ovr_ff)
        else $error("locked arrival not flagged");
    a_locked_no_growth: assert property (s_locked_arrival |=> count <= $past(count))
        else $error("watermark buffer grew while locked");
    a_stream_overwrite: assert property (s_full_stream_store |=> ovr_ff && count == DEPTH_CNT)
        else $error("streaming overwrite missing overrun");
    a_stream_grows: assert property ((store_en && stream_mode && count < DEPTH_CNT && !pop_en)
        |=> count == CW'($past(count) + 1'b1))
        else $error("streaming store lost");
    a_irq_gated: assert property (!(|(status[IRQ_SRC_W-1:0] & ctrl_ff[IRQ_EN_LSB +: IRQ_SRC_W]))
        |=> !irq)
        else $error("interrupt without enabled event");
    a_diag_gated: assert property ((standby_mode && standby_diag_gate) |=> !diag_enable)
        else $error("diagnostics on in gated standby");
    a_osc_kept: assert property ((standby_mode && standby_diag_gate && osc_diag_errors_en)
        |=> osc_keep_on)
        else $error("oscillator not kept on");
    a_empty_read_zero: assert property ((service && count == '0) |=>
        next_word_ff == '0 && rd_err_ff)
        else $error("empty read not zero");
    a_read_yields: assert property (store_en |-> !pop_en)
        else $error("read during result write");
endmodule // conversion_result_fifo
`default_nettype wire

// ==== rtl/fifo_pkg.sv ====
// Constants shared by the conversion result buffer and its ring storage.
// Assumes a single device clock; the serial port clock is sampled, not used as a clock.
`default_nettype none
package fifo_pkg;
    // Storage geometry
    localparam int DEPTH = 256;
    localparam int AW = 8;
    localparam int CW = 9;
    localparam int WORD_W = 32;
    localparam int DATA_W = 24;
    localparam int HDR_W = 8;
    localparam logic [CW-1:0] DEPTH_CNT = 9'h100;

    // Register addresses as carried in the command byte
    localparam logic [5:0] REG_CTRL = 6'h3A;
    localparam logic [5:0] REG_STATUS = 6'h3B;
    localparam logic [5:0] REG_DATA = 6'h3D;
    localparam int CMD_READ_BIT = 6;

    // Control register layout and reset
    localparam logic [23:0] CTRL_RESET = 24'h040200;
    localparam logic [23:0] CTRL_WMASK = 24'h0F7FFF;
    localparam int MODE_LSB = 16;
    localparam int ADD_HDR_BIT = 18;
    localparam int ADD_STAT_BIT = 19;
    localparam int IRQ_EN_LSB = 8;
    localparam int WM_LSB = 0;

    // Buffer modes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_WM = 2'h1;
    localparam logic [1:0] MODE_STREAM = 2'h2;

    // Status bit positions
    localparam int ST_EMPTY = 0;
    localparam int ST_WM = 1;
    localparam int ST_OVR = 2;
    localparam int ST_LOW = 3;
    localparam int ST_HIGH = 4;
    localparam int ST_RD_ERR = 5;
    localparam int ST_WR_ERR = 6;
    localparam int ST_MASTER = 7;
    localparam int IRQ_SRC_W = 7;

    // Header bit positions inside the stored word
    localparam int HDR_THRESH = 6;
    localparam int HDR_WM = 5;
    localparam int HDR_EMPTY = 4;

    // Serial field lengths in clock bits
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] CTRL_LAST = 5'h17;
    localparam logic [4:0] CNT_LAST = 5'h07;
    localparam logic [5:0] LEN_HDR = 6'h20;
    localparam logic [5:0] LEN_NOHDR = 6'h18;

    // Watermark field to sample count, zero meaning a full buffer
    function automatic logic [CW-1:0] level_of(input logic [7:0] wm);
        level_of = (wm == 8'h00) ? DEPTH_CNT : {1'b0, wm};
    endfunction
endpackage
`default_nettype wire

// ==== rtl/sample_ring.sv ====
// Ring storage of 32-bit entries with occupancy count and overwrite of the oldest.
// Assumes the owner never pops while empty and never pops in a push cycle.
`timescale 1ns/1ps
`default_nettype none
module sample_ring import fifo_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic push,
    input wire logic pop,
    input wire logic [WORD_W-1:0] push_data,
    output logic [WORD_W-1:0] pop_data,
    output logic [CW-1:0] count
);
    logic [WORD_W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;
    logic full;
    logic overwrite;

    assign full = (count_ff == DEPTH_CNT);
    assign overwrite = push && full && !pop;
    assign pop_data = mem[rd_ptr_ff];
    assign count = count_ff;

    // Entry storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= push_data;
        end
    end

    // Pointers; a push into a full ring drops the oldest entry
    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
            end
            if (pop || overwrite) begin
                rd_ptr_ff <= AW'(rd_ptr_ff + 1'b1);
            end
        end
    end

    // Occupancy, capped at the depth
    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            count_ff <= '0;
        end else if (push && !pop && !full) begin
            count_ff <= CW'(count_ff + 1'b1);
        end else if (pop && !push) begin
            count_ff <= CW'(count_ff - 1'b1);
        end
    end

    a_count_bound: assert property (@(posedge clk) disable iff (!rst_n)
        count_ff <= DEPTH_CNT)
        else $error("ring count above depth");

    a_overwrite_oldest: assert property (@(posedge clk) disable iff (!rst_n)
        (overwrite && !clear) |=> (count_ff == DEPTH_CNT)
            && (rd_ptr_ff == AW'($past(rd_ptr_ff) + 1'b1)))
        else $error("full push did not drop oldest entry");
endmodule // sample_ring
`default_nettype wire

// ==== verif/spi_host.sv ====
// Host model on the serial port: mode 3, link clock 320 ns, stands high between frames.
// Assumes clk at 40 ns; pins change only just after clk rising edges.
`timescale 1ns/1ps
`default_nettype none
module spi_host (
    input wire logic clk,
    input wire logic miso,
    output logic cs_n,
    output logic sclk,
    output logic mosi
);
    // Idle pins at time zero
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        mosi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic frame_start();
        tick(1);
        cs_n <= 1'b0;
        tick(4);
    endtask
    // Released data line shows the inverse of its last bit
    task automatic frame_end();
        tick(4);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        tick(4);
    endtask
    // Shift n bits MSB first; sample just before each rising edge
    task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        for (int i = n - 1; i >= 0; i--) begin
            sclk <= 1'b0;
            mosi <= tx[i];
            tick(4);
            rx[i] = miso;
            sclk <= 1'b1;
            tick(4);
        end
    endtask
endmodule // spi_host
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the conversion result buffer.
// Assumes spi_host as the serial host; results are pushed on clk.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fifo_pkg::*;
    localparam logic [4:0] TS = 5'h10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic vld = 1'b0;
    logic [23:0] dat = '0;
    logic [3:0] ch = '0;
    logic hi = 1'b0;
    logic lo = 1'b0;
    logic [2:0] mode_in = '0;
    logic [4:0] psel = '0;
    logic [4:0] nsel = '0;
    wire logic cs_n, sclk, mosi, miso, oe, diag, osc_on, t_pos, t_neg, irq, line;
    logic [31:0] exp_w [0:259];
    logic [31:0] rx;
    logic [7:0] sticky = '0;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    assign line = oe ? miso : 1'bz;
    conversion_result_fifo #(.TEMP_SENSOR_SEL(TS)) conversion_result_fifo_inst (
        .clk(clk), .rst_n(rst_n), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe(oe), .result_valid(vld), .result_data(dat),
        .result_channel(ch), .result_above_high(hi), .result_below_low(lo),
        .standby_mode(mode_in[2]), .standby_diag_gate(mode_in[1]),
        .osc_diag_errors_en(mode_in[0]), .positive_input_select(psel),
        .negative_input_select(nsel), .diag_enable(diag), .osc_keep_on(osc_on),
        .temp_sensor_pos(t_pos), .temp_sensor_neg(t_neg), .irq(irq));
    spi_host spi_host_inst (.clk(clk), .miso(line), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One register frame: command byte then n bits
    task automatic xfer(input logic [7:0] c, input logic [31:0] d, input int n);
        spi_host_inst.frame_start();
        spi_host_inst.shift({24'h0, c}, 8, rx);
        spi_host_inst.shift(d, n, rx);
        spi_host_inst.frame_end();
    endtask
    // Expected entry: threshold, watermark, empty clear, channel, then the result
    function automatic logic [31:0] entry_of(input bit thr, input bit wm, input logic [3:0] c,
                                             input logic [23:0] d);
        entry_of = {1'b0, thr, wm, 1'b0, c, d};
    endfunction
    // Pulse one result and record the word it should become
    task automatic push(input int i, input bit t, input int lvl);
        @(posedge clk);
        vld <= 1'b1;
        dat <= 24'($urandom);
        ch <= 4'($urandom);
        hi <= t && $urandom_range(1);
        lo <= t && $urandom_range(1);
        @(posedge clk);
        vld <= 1'b0;
        sticky |= {3'h0, hi, lo, 3'h0};
        exp_w[i] = entry_of(hi | lo, (i < 256 ? i + 1 : 256) >= lvl, ch, dat);
    endtask
    // Readback of n words of len bits from entry first with avail entries held
    task automatic rb(input int n, input int first, input int avail, input int len);
        logic [31:0] e;
        spi_host_inst.frame_start();
        spi_host_inst.shift(32'h7D, 8, rx);
        spi_host_inst.shift(32'(n % 256), 8, rx);
        for (int j = 0; j < n; j++) begin
            e = (j < avail) ? exp_w[first + j] : 32'h0;
            if (j == avail - 1) e[28] = 1'b1;
            if (len == 24) e = {8'h00, e[23:0]};
            spi_host_inst.shift(32'h0, len, rx);
            chk("word", e, rx);
        end
        spi_host_inst.frame_end();
    endtask
    initial begin
        void'($urandom(32'h3AD0));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        xfer(8'h7A, 32'h0, 24);
        chk("ctrl", 32'h040200, rx);
        xfer(8'h7B, 32'h0, 8);
        chk("status", 32'h01, rx);
        xfer(8'h7C, 32'h0, 8);
        chk("unmapped", 32'h0, rx);
        chk("irq", 32'h0, irq);
        chk("oe", 32'h0, oe);
        $display("test reset done");
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            mode_in <= 3'(k);
            psel <= (k % 3 == 0) ? TS : 5'($urandom);
            nsel <= (k % 4 == 1) ? TS : 5'($urandom);
            repeat (3) @(posedge clk);
            chk("diag", !(mode_in[2] && mode_in[1]), diag);
            chk("osc", &mode_in, osc_on);
            chk("tpos", psel == TS, t_pos);
            chk("tneg", nsel == TS, t_neg);
        end
        $display("test standby done");
        xfer(8'h3A, 32'h050204, 24);
        for (int i = 0; i < 4; i++) push(i, 1, 4);
        push(4, 0, 4);
        xfer(8'h7B, 32'h0, 8);
        chk("status", 32'hC6 | sticky, rx);
        chk("irq", 32'h1, irq);
        chk("oe", 32'h1, oe);
        chk("ready", 32'h0, miso);
        rb(4, 0, 4, 32);
        rb(1, 0, 0, 32);
        xfer(8'h7B, 32'h0, 8);
        chk("status", 32'hE1 | sticky, rx);
        chk("irq", 32'h0, irq);
        $display("test watermark done");
        xfer(8'h3A, 32'h040000, 24);
        xfer(8'h7B, 32'h0, 8);
        chk("status", 32'h01, rx);
        xfer(8'h3A, 32'h060000, 24);
        for (int i = 0; i < 258; i++) push(i, 0, 256);
        xfer(8'h7B, 32'h0, 8);
        chk("status", 32'h06, rx);
        chk("irq", 32'h0, irq);
        rb(2, 2, 256, 32);
        xfer(8'h3A, 32'h020000, 24);
        rb(2, 4, 256, 24);
        $display("test streaming done");
        xfer(8'h3A, 32'h070000, 24);
        xfer(8'h7A, 32'h0, 24);
        chk("ctrl", 32'h070000, rx);
        xfer(8'h7B, 32'h0, 8);
        chk("status", 32'h01, rx);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        xfer(8'h7A, 32'h0, 24);
        chk("ctrl", 32'h040200, rx);
        chk("irq", 32'h0, irq);
        chk("oe", 32'h0, oe);
        $display("test mode and reset done");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
